// ==== hw/host_link_pkg.sv ====
// Shared constants for the host-bus link: the register map seen across the link,
// the reset timing and the state encodings of both ends.
// Assumes a single 250 MHz clock shared by both ends of the link.
package host_link_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int GLOBAL_RESET_MIN_MS = 2;
  // A least time, so the cycle count rounds up.
  localparam int GLOBAL_RESET_CYCLES =
    (GLOBAL_RESET_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_RESET_CYCLES = 16;

  localparam int AD_WIDTH = 32;

  // Word offsets of the device registers reached across the link.
  localparam logic [1:0] REG_CONTROL = 2'h0;
  localparam logic [1:0] REG_PM_CONTEXT = 2'h1;
  localparam logic [1:0] REG_VENDOR = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  localparam int REG_INDEX_LSB = 2;
  localparam int STATUS_INT_BIT = 0;

  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] PM_CONTEXT_RESET = 32'h0000_0000;
  localparam logic [31:0] VENDOR_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_WRITE_DATA = 2'b01,
    DEV_READ_TURN = 2'b10,
    DEV_READ_DATA = 2'b11
  } dev_state_type;

  typedef enum logic [2:0] {
    HOST_POWER_ON = 3'b000,
    HOST_BUS_RESET = 3'b001,
    HOST_IDLE = 3'b010,
    HOST_ADDR = 3'b011,
    HOST_WRITE_DATA = 3'b100,
    HOST_READ_TURN = 3'b101,
    HOST_READ_WAIT = 3'b110
  } host_state_type;

endpackage

// ==== hw/host_link_if.sv ====
// Interface joining the host end and the device end of the host bus.
// Resolves the shared address/data lines, the target ready line and the
// interrupt pin from the drivers' enables; the clock comes from outside.
`timescale 1ns/1ps
interface host_link_if;
  logic global_reset;
  logic bus_reset;
  logic frame;
  logic write_cmd;
  logic data_valid;
  logic [31:0] ad_host;
  logic ad_host_oe;
  logic [31:0] ad_dev;
  logic ad_dev_oe;
  logic [31:0] ad;
  logic target_ready_out;
  logic target_ready_oe;
  logic target_ready;
  logic int_pin_out;
  logic int_pin_oe;
  logic int_pin;

  // Undriven lines settle to a defined level: data low, ready low, interrupt pulled up.
  assign ad = ad_dev_oe ? ad_dev : (ad_host_oe ? ad_host : 32'h0000_0000);
  assign target_ready = target_ready_oe & target_ready_out;
  assign int_pin = int_pin_oe ? int_pin_out : 1'b1;

  modport host (
    output global_reset, bus_reset, frame, write_cmd, data_valid, ad_host, ad_host_oe,
    input ad, target_ready, int_pin
  );
  modport device (
    input global_reset, bus_reset, frame, write_cmd, data_valid, ad, 
    output ad_dev, ad_dev_oe, target_ready_out, target_ready_oe, int_pin_out, int_pin_oe
  );
endinterface

// ==== hw/host_bus_device.sv ====
// Device end of the host bus: reset handling, bus target for four link registers,
// and the interrupt pin in host or card mode.
// Assumes the host end drives the link on the same clock and keeps its own timing.
`timescale 1ns/1ps
// Operation
// - Global reset clears every register, spared included
// - Global reset: inactive, all drivers released
// - System holds global reset at least 2 ms
// - System gives separate global and bus resets
// - Bus reset: drivers off, spares context bits
// - All link signals sampled on rising clock
// - Interrupt pin; card interrupt when strap low
// - Address phase carries 32-bit address
// - Data phase carries the data word
module host_bus_device
  import host_link_pkg::*;
(
  // Clock and enable
  input wire logic clk,
  input wire logic ce,
  // Link
  host_link_if.device link,
  // User side
  input wire logic card_mode_strap,
  input wire logic irq_event,
  output logic [31:0] control_out,
  output logic [31:0] pm_context_out,
  output logic card_mode,
  output logic functional
);

  // The device assumes two separate resets arrive on the link.
  logic any_reset;
  assign any_reset = link.global_reset | link.bus_reset;

  dev_state_type state_q, state_d;
  logic [1:0] index_q, index_d;
  logic [31:0] control_q;
  logic [31:0] pm_context_q;
  logic [31:0] vendor_q;
  logic load_control;
  logic load_pm_context;
  logic load_vendor;
  logic int_pending_q, int_pending_d;
  logic [31:0] read_data_q, read_data_d;
  logic read_drive_q, read_drive_d;
  logic strap_q, strap_d;
  logic [31:0] read_mux;
  logic write_now;
  logic status_clear;

  // Read multiplexer over the four link registers.
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (index_q)
      REG_CONTROL: read_mux = control_q;
      REG_PM_CONTEXT: read_mux = pm_context_q;
      REG_VENDOR: read_mux = vendor_q;
      REG_STATUS: read_mux[STATUS_INT_BIT] = int_pending_q;
    endcase
  end

  // A write lands when the host marks its data phase valid.
  assign write_now = (state_q == DEV_WRITE_DATA) && link.data_valid;
  assign status_clear = write_now && (index_q == REG_STATUS) && link.ad[STATUS_INT_BIT];

  // Transaction sequencing; everything is taken on the rising edge.
  always_comb begin
    state_d = state_q;
    index_d = index_q;
    read_data_d = read_data_q;
    read_drive_d = 1'b0;
    unique case (state_q)
      DEV_IDLE: begin
        if (link.frame) begin
          index_d = link.ad[REG_INDEX_LSB +: 2];
          state_d = link.write_cmd ? DEV_WRITE_DATA : DEV_READ_TURN;
        end
      end
      DEV_WRITE_DATA: begin
        if (link.data_valid) begin
          state_d = DEV_IDLE;
        end
      end
      DEV_READ_TURN: begin
        read_data_d = read_mux;
        read_drive_d = 1'b1;
        state_d = DEV_READ_DATA;
      end
      DEV_READ_DATA: begin
        state_d = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (link.global_reset || link.bus_reset) begin
      state_q <= DEV_IDLE;
      index_q <= 2'h0;
      read_data_q <= 32'h0000_0000;
      read_drive_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      index_q <= index_d;
      read_data_q <= read_data_d;
      read_drive_q <= read_drive_d;
    end
  end

  // Loads of the link registers; the spared words take no write under the bus reset.
  assign load_control = write_now && (index_q == REG_CONTROL);
  assign load_pm_context = write_now && (index_q == REG_PM_CONTEXT) && !link.bus_reset;
  assign load_vendor = write_now && (index_q == REG_VENDOR) && !link.bus_reset;

  // Ordinary register: either reset returns it to its default.
  link_word_reg #(.WIDTH(AD_WIDTH), .RESET_VALUE(CONTROL_RESET)) control_reg_inst (
    .clk(clk),
    .ce(ce),
    .clear(any_reset),
    .load(load_control),
    .load_value(link.ad),
    .value(control_q)
  );

  // Context and vendor bits survive a bus reset so wake-up state is not lost;
  // only the one-time power-on reset returns them to their defaults.
  link_word_reg #(.WIDTH(AD_WIDTH), .RESET_VALUE(PM_CONTEXT_RESET)) pm_context_reg_inst (
    .clk(clk),
    .ce(ce),
    .clear(link.global_reset),
    .load(load_pm_context),
    .load_value(link.ad),
    .value(pm_context_q)
  );

  link_word_reg #(.WIDTH(AD_WIDTH), .RESET_VALUE(VENDOR_RESET)) vendor_reg_inst (
    .clk(clk),
    .ce(ce),
    .clear(link.global_reset),
    .load(load_vendor),
    .load_value(link.ad),
    .value(vendor_q)
  );

  // Pending interrupt; the event wins over a clear in the same cycle, so an event
  // that lands while software acknowledges the last one is not lost.
  always_comb begin
    int_pending_d = int_pending_q;
    if (status_clear) begin
      int_pending_d = 1'b0;
    end
    if (irq_event) begin
      int_pending_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (any_reset) begin
      int_pending_q <= 1'b0;
    end else if (ce) begin
      int_pending_q <= int_pending_d;
    end
  end

  // The strap is caught by a clocked process while any reset is held, so the
  // pin mode is fixed before the device becomes functional.
  always_comb begin
    strap_d = strap_q;
    if (any_reset) begin
      strap_d = card_mode_strap;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      strap_q <= strap_d;
    end
  end

  // Output drivers are forced off while either reset is held, whatever the flops hold.
  assign link.ad_dev = read_data_q;
  assign link.ad_dev_oe = read_drive_q & ~any_reset;
  assign link.target_ready_out = read_drive_q;
  assign link.target_ready_oe = ~any_reset;

  // Host mode is open-drain, low when pending; card mode (strap low) drives both levels.
  assign link.int_pin_out = ~int_pending_q;
  assign link.int_pin_oe = ~any_reset & (int_pending_q | ~strap_q);

  assign control_out = control_q;
  assign pm_context_out = pm_context_q;
  assign card_mode = ~strap_q;
  assign functional = ~any_reset;

endmodule

// One link register word: takes the bus word on a load strobe and returns to its
// default on clear. Clear acts whatever the clock enable does.
module link_word_reg
  import host_link_pkg::*;
#(
  parameter int WIDTH = AD_WIDTH,
  parameter logic [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
)
(
  // Clock and enable
  input wire logic clk,
  input wire logic ce,
  // Control
  input wire logic clear,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  // Contents
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] value_q, value_d;

  always_comb begin
    value_d = value_q;
    if (load) begin
      value_d = load_value;
    end
  end

  always_ff @(posedge clk) begin
    if (clear) begin
      value_q <= RESET_VALUE;
    end else if (ce) begin
      value_q <= value_d;
    end
  end

  assign value = value_q;

endmodule

// ==== hw/host_bus_host.sv ====
// Host end of the host bus: power-on and bus reset generation and a simple
// initiator that runs one read or write at a time.
// Assumes the device end shares the clock and the interface resolves the lines.
`timescale 1ns/1ps
module host_bus_host
  import host_link_pkg::*;
#(
  parameter int GLOBAL_RESET_LEN = GLOBAL_RESET_CYCLES
)
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Link
  host_link_if.host link,
  // Requests
  input wire logic bus_reset_req,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic req_ready,
  // Answers
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic interrupt_seen
);

  host_state_type state_q, state_d;
  logic [31:0] count_q, count_d;
  logic [31:0] addr_q, addr_d;
  logic [31:0] wdata_q, wdata_d;
  logic write_q, write_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [31:0] rsp_rdata_q, rsp_rdata_d;
  logic int_q, int_d;

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    write_d = write_q;
    rsp_valid_d = 1'b0;
    rsp_rdata_d = rsp_rdata_q;
    int_d = ~link.int_pin;
    unique case (state_q)
      HOST_POWER_ON: begin
        // Global reset is held for the full minimum, once, after power-on.
        if (count_q >= 32'(GLOBAL_RESET_LEN - 1)) begin
          state_d = HOST_IDLE;
          count_d = 32'h0000_0000;
        end else begin
          count_d = count_q + 32'h0000_0001;
        end
      end
      HOST_BUS_RESET: begin
        if (count_q >= 32'(BUS_RESET_CYCLES - 1)) begin
          state_d = HOST_IDLE;
          count_d = 32'h0000_0000;
        end else begin
          count_d = count_q + 32'h0000_0001;
        end
      end
      HOST_IDLE: begin
        if (bus_reset_req) begin
          state_d = HOST_BUS_RESET;
          count_d = 32'h0000_0000;
        end else if (req_valid) begin
          addr_d = req_addr;
          wdata_d = req_wdata;
          write_d = req_write;
          state_d = HOST_ADDR;
        end
      end
      HOST_ADDR: begin
        state_d = write_q ? HOST_WRITE_DATA : HOST_READ_TURN;
      end
      HOST_WRITE_DATA: begin
        rsp_valid_d = 1'b1;
        state_d = HOST_IDLE;
      end
      HOST_READ_TURN: begin
        state_d = HOST_READ_WAIT;
      end
      HOST_READ_WAIT: begin
        if (link.target_ready) begin
          rsp_valid_d = 1'b1;
          rsp_rdata_d = link.ad;
          state_d = HOST_IDLE;
        end
      end
      default: begin
        state_d = HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= HOST_POWER_ON;
      count_q <= 32'h0000_0000;
      addr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      write_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 32'h0000_0000;
      int_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      count_q <= count_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      write_q <= write_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_rdata_q <= rsp_rdata_d;
      int_q <= int_d;
    end
  end

  // Bus reset also covers the power-on window so the device sees both resets.
  assign link.global_reset = (state_q == HOST_POWER_ON);
  assign link.bus_reset = (state_q == HOST_POWER_ON) || (state_q == HOST_BUS_RESET);
  assign link.frame = (state_q == HOST_ADDR);
  assign link.write_cmd = write_q;
  assign link.data_valid = (state_q == HOST_WRITE_DATA);
  assign link.ad_host = (state_q == HOST_ADDR) ? addr_q : wdata_q;
  assign link.ad_host_oe = (state_q == HOST_ADDR) || (state_q == HOST_WRITE_DATA);

  assign req_ready = (state_q == HOST_IDLE) && !bus_reset_req;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign interrupt_seen = int_q;

endmodule

// ==== sim/host_link_chk.sv ====
// Checker for the host link: watches the resolved link signals of both ends.
// Assumes one clock for both ends and the bench reset as the host reset.
`timescale 1ns/1ps
module host_link_chk
  import host_link_pkg::*;
#(
  parameter int GLOBAL_RESET_LEN = GLOBAL_RESET_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link
  input wire logic global_reset,
  input wire logic bus_reset,
  input wire logic frame,
  input wire logic write_cmd,
  input wire logic data_valid,
  input wire logic ad_host_oe,
  input wire logic ad_dev_oe,
  input wire logic target_ready,
  input wire logic target_ready_oe,
  input wire logic int_pin_oe
);
  int hold_q;
  int hold_d;

  // Counts the cycles for which the power-on reset has stood high.
  always_comb begin
    hold_d = global_reset ? hold_q + 1 : 0;
  end
  always_ff @(posedge clk) begin
    hold_q <= hold_d;
  end

  sequence s_turn;
    !ad_host_oe && !ad_dev_oe;
  endsequence
  sequence s_answer;
    ad_dev_oe && target_ready;
  endsequence

  property p_quiet;
    @(posedge clk) disable iff (reset)
      (global_reset || bus_reset) |-> !ad_dev_oe && !target_ready_oe && !int_pin_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("device drives during reset");
  property p_hold;
    @(posedge clk) disable iff (reset) $fell(global_reset) |-> hold_q >= GLOBAL_RESET_LEN;
  endproperty
  a_hold: assert property (p_hold) else $error("power-on reset too short");
  property p_both;
    @(posedge clk) disable iff (reset) global_reset |-> bus_reset;
  endproperty
  a_both: assert property (p_both) else $error("bus reset not given with power-on");
  property p_addr;
    @(posedge clk) disable iff (reset) frame |-> ad_host_oe && !ad_dev_oe;
  endproperty
  a_addr: assert property (p_addr) else $error("address phase not driven by host");
  property p_wdata;
    @(posedge clk) disable iff (reset) frame && write_cmd |=> data_valid && ad_host_oe;
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data phase missing");
  property p_read;
    @(posedge clk) disable iff (reset || bus_reset) frame && !write_cmd |=> s_turn ##1 s_answer;
  endproperty
  a_read: assert property (p_read) else $error("read answer out of place");
  property p_pulse;
    @(posedge clk) disable iff (reset) target_ready |=> !target_ready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_cause;
    @(posedge clk) disable iff (reset) target_ready |-> $past(frame, 2) && !$past(write_cmd, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("ready without a read");
  property p_contend;
    @(posedge clk) disable iff (reset) !(ad_dev_oe && ad_host_oe);
  endproperty
  a_contend: assert property (p_contend) else $error("both ends drive the lines");
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench: host end and device end joined by the link interface.
// Assumes a 250 MHz clock and a shortened power-on window of 20 cycles.
`timescale 1ns/1ps
module testbench
  import host_link_pkg::*;
;
  localparam int LEN = 20;
  typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} row_type;
  logic clk, reset, ce, bus_reset_req, req_valid, req_write, card_mode_strap, irq_event;
  logic req_ready, rsp_valid, interrupt_seen, card_mode, functional;
  logic [31:0] req_addr, req_wdata, rsp_rdata, control_out, pm_context_out, r;
  int mismatches, n_tests, cnt;
  row_type rows [7];

  host_link_if link();
  host_bus_host #(.GLOBAL_RESET_LEN(LEN)) host_bus_host_inst (.clk(clk), .reset(reset),
    .ce(ce), .link(link), .bus_reset_req(bus_reset_req), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .interrupt_seen(interrupt_seen));
  host_bus_device host_bus_device_inst (.clk(clk), .ce(ce), .link(link),
    .card_mode_strap(card_mode_strap), .irq_event(irq_event), .control_out(control_out),
    .pm_context_out(pm_context_out), .card_mode(card_mode), .functional(functional));
  host_link_chk #(.GLOBAL_RESET_LEN(LEN)) host_link_chk_inst (.clk(clk), .reset(reset),
    .global_reset(link.global_reset), .bus_reset(link.bus_reset), .frame(link.frame),
    .write_cmd(link.write_cmd), .data_valid(link.data_valid), .ad_host_oe(link.ad_host_oe),
    .ad_dev_oe(link.ad_dev_oe), .target_ready(link.target_ready),
    .target_ready_oe(link.target_ready_oe), .int_pin_oe(link.int_pin_oe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp, input string msg);
    chk_word({31'h0000_0000, got}, {31'h0000_0000, exp}, msg);
  endtask

  // The request is raised once req_ready is seen high and is held for one clock only.
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(negedge clk);
    for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(negedge clk);
    chk_bit(rsp_valid, 1'b1, "no answer");
    r = rsp_rdata;
  endtask

  // Starts a reset window from the host and waits for it to end.
  task run_reset(input logic host);
    int i;
    @(negedge clk);
    if (host) reset = 1'b1;
    else bus_reset_req = 1'b1;
    repeat (host ? 5 : 1) @(negedge clk);
    reset = 1'b0;
    bus_reset_req = 1'b0;
    chk_bit(functional, 1'b0, "functional in reset");
    chk_bit(link.ad_dev_oe | link.int_pin_oe | link.target_ready_oe, 1'b0, "drives");
    chk_bit(link.int_pin, 1'b1, "pin not released");
    cnt = 0;
    for (i = 0; i < 200 && link.bus_reset === 1'b1; i++) begin
      if (link.global_reset === 1'b1) cnt++;
      @(negedge clk);
    end
    chk_bit(functional, 1'b1, "not functional after reset");
  endtask

  task irq_pulse();
    @(negedge clk);
    irq_event = 1'b1;
    @(negedge clk);
    irq_event = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  initial begin
    #20000;
    mismatches++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    bus_reset_req = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 32'h0000_0000;
    req_wdata = 32'h0000_0000;
    card_mode_strap = 1'b1;
    irq_event = 1'b0;
    rows = '{'{1'b1, 32'h0000_0000, 32'hA5A5_0F0F, 32'h0000_0000},
             '{1'b1, 32'h0000_0004, 32'h1234_5678, 32'h0000_0000},
             '{1'b1, 32'h0000_0008, 32'hCAFE_0001, 32'h0000_0000},
             '{1'b0, 32'h0000_0000, 32'h0000_0000, 32'hA5A5_0F0F},
             '{1'b0, 32'h0000_0004, 32'h0000_0000, 32'h1234_5678},
             '{1'b0, 32'h0000_0008, 32'h0000_0000, 32'hCAFE_0001},
             '{1'b0, 32'h0000_000C, 32'h0000_0000, 32'h0000_0000}};
    run_reset(1'b1);
    chk_bit(cnt >= LEN, 1'b1, "power-on window short");
    $display("Test power-on done");
    foreach (rows[k]) begin
      xfer(rows[k].w, rows[k].a, rows[k].d);
      if (!rows[k].w) chk_word(r, rows[k].e, "read data");
    end
    chk_word(control_out, 32'hA5A5_0F0F, "control");
    chk_word(pm_context_out, 32'h1234_5678, "context");
    $display("Test table done");
    run_reset(1'b0);
    xfer(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk_word(r, CONTROL_RESET, "control kept");
    xfer(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk_word(r, 32'h1234_5678, "context lost");
    xfer(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk_word(r, 32'hCAFE_0001, "vendor lost");
    $display("Test bus reset done");
    irq_pulse();
    chk_bit(link.int_pin, 1'b0, "host interrupt");
    chk_bit(interrupt_seen, 1'b1, "interrupt seen");
    xfer(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk_bit(r[STATUS_INT_BIT], 1'b1, "pending");
    xfer(1'b1, 32'h0000_000C, 32'h0000_0001);
    repeat (2) @(negedge clk);
    chk_bit(link.int_pin, 1'b1, "interrupt cleared");
    chk_bit(link.int_pin_oe, 1'b0, "open drain idle");
    $display("Test host interrupt done");
    card_mode_strap = 1'b0;
    run_reset(1'b0);
    chk_bit(card_mode, 1'b1, "card mode");
    chk_bit(link.int_pin_oe, 1'b1, "card pin driven");
    irq_pulse();
    chk_bit(link.int_pin, 1'b0, "card interrupt");
    xfer(1'b1, 32'h0000_000C, 32'h0000_0001);
    repeat (2) @(negedge clk);
    chk_bit(link.int_pin, 1'b1, "card interrupt cleared");
    $display("Test card interrupt done");
    @(negedge clk);
    ce = 1'b0;
    irq_pulse();
    chk_bit(link.int_pin, 1'b1, "pending moved while frozen");
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(link.int_pin, 1'b1, "late pending after freeze");
    $display("Test clock enable done");
    run_reset(1'b1);
    chk_word(pm_context_out, PM_CONTEXT_RESET, "context after power-on");
    xfer(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk_word(r, VENDOR_RESET, "vendor after power-on");
    $display("Test second power-on done");
    final_report();
  end
endmodule
